// ### hdl/xrm_lane_dec.sv
module xrm_lane_dec (
    input wire logic clk,
    input wire logic nrst,
    input wire logic code_valid,
    input wire logic [xrm_pkg::CODE_W-1:0] code,
    output xrm_pkg::xrm_sym_t sym,
    output logic sym_valid
);
    // 6b search over both disparity columns, returns {hit, edcba}
    function automatic logic [5:0] dec6(input logic [5:0] c);
        logic [5:0] r;
        logic [5:0] p;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            p = ($countones(xrm_pkg::TBL6[i]) == xrm_pkg::BAL6
                && i != xrm_pkg::D7_IDX) ? xrm_pkg::TBL6[i]
                : ~xrm_pkg::TBL6[i];
            if (c == xrm_pkg::TBL6[i] || c == p) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : dec6

    // 4b search over both disparity columns, returns {hit, hgf}
    function automatic logic [3:0] dec4(input logic [3:0] c);
        logic [3:0] r;
        logic [3:0] p;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            p = ($countones(xrm_pkg::TBL4[i]) == xrm_pkg::BAL4
                && i != xrm_pkg::D3_IDX) ? xrm_pkg::TBL4[i]
                : ~xrm_pkg::TBL4[i];
            if (c == xrm_pkg::TBL4[i] || c == p) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : dec4

    // split code group and look both halves up
    wire logic [5:0] six = code[xrm_pkg::CODE_W-1:xrm_pkg::SIX_LSB];
    wire logic [3:0] four = code[xrm_pkg::SIX_LSB-1:0];
    wire logic [5:0] r6 = dec6(six);
    wire logic [3:0] r4 = dec4(four);
    wire logic k28 = six == xrm_pkg::K28_6 || six == ~xrm_pkg::K28_6;
    wire logic alt = four == xrm_pkg::ALT4 || four == ~xrm_pkg::ALT4;
    wire logic kx7 = alt && (r6[4:0] == xrm_pkg::KX7_A
        || r6[4:0] == xrm_pkg::KX7_B || r6[4:0] == xrm_pkg::KX7_C
        || r6[4:0] == xrm_pkg::KX7_D);
    wire logic [4:0] x5 = k28 ? xrm_pkg::K28_IDX : r6[4:0];
    wire logic [2:0] y3 = alt ? xrm_pkg::Y7 : r4[2:0];
    wire logic bad = ~((k28 | r6[5]) & (alt | r4[3]));

    // running disparity is not policed; only unknown codes flag err
    // [R15] decode to byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sym <= '0;
            sym_valid <= 1'b0;
        end else begin
            sym <= '{data: {y3, x5}, k: k28 | kx7, err: bad};
            sym_valid <= code_valid;
        end
    end

    AST_DEC_IDLE: assert property (@(posedge clk) disable iff (!nrst) // [R15]
        code_valid && code == xrm_pkg::K28_0_NEG |=>
        sym_valid && sym.k && !sym.err && sym.data == xrm_pkg::R_BYTE)
        else $error("idle code group not decoded as control 1C");
endmodule : xrm_lane_dec

// ### hdl/xrm_pkg.sv
package xrm_pkg;
    // lane and code group geometry
    localparam int LANES = 4;
    localparam int CODE_W = 10;
    localparam int SIX_LSB = 4;
    localparam int BYTE_W = 8;

    // rate match fifo geometry and fill marks
    localparam int FIFO_DEPTH = 16;
    localparam int AW = 4;
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] FULL_LVL = 5'h10;
    localparam logic [PW-1:0] HI_MARK = 5'h0C;
    localparam logic [PW-1:0] MID_MARK = 5'h08;
    localparam logic [PW-1:0] LO_MARK = 5'h04;
    // total offset the marks are sized for, in ppm
    localparam int RM_PPM_TOTAL = 200;
    // columns between two one-column slips at the worst offset
    localparam int SLIP_COLS = 1000000 / RM_PPM_TOTAL;

    // full and empty flags stand this many cycles at least
    localparam logic [1:0] HOLD_CYC = 2'h3;
    // shortest internal reset, in parallel clock cycles
    localparam int RST_MIN_CYC = 2;

    // code group values
    localparam logic [7:0] R_BYTE = 8'h1C;
    localparam logic [7:0] ERR_BYTE = 8'hFE;
    localparam logic [9:0] K28_0_NEG = 10'h0F4;
    localparam logic [5:0] K28_6 = 6'h0F;
    localparam logic [4:0] K28_IDX = 5'h1C;
    localparam logic [3:0] ALT4 = 4'h7;
    localparam logic [2:0] Y7 = 3'h7;
    localparam int BAL6 = 3;
    localparam int BAL4 = 2;
    localparam int D7_IDX = 7;
    localparam int D3_IDX = 3;
    localparam logic [4:0] KX7_A = 5'h17;
    localparam logic [4:0] KX7_B = 5'h1B;
    localparam logic [4:0] KX7_C = 5'h1D;
    localparam logic [4:0] KX7_D = 5'h1E;
    // 5b/6b codes for negative running disparity, index is EDCBA
    localparam logic [5:0] TBL6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    // 3b/4b codes for negative running disparity, index is HGF
    localparam logic [3:0] TBL4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] A_CLEAR = 8'h04;
    localparam logic [ADDR_W-1:0] A_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] A_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] A_STATE = 8'h10;
    // event bits of status, clear and enable
    localparam int EV_DEL = 0;
    localparam int EV_INS = 1;
    localparam int EV_FULL = 2;
    localparam int EV_EMPTY = 3;
    localparam int EV_ALIGN = 4;
    localparam int EV_W = 5;
    // control and state fields
    localparam int CTRL_RM_EN = 0;
    localparam logic CTRL_RM_EN_RST = 1'b1;
    localparam int ST_ACT = 8;
    localparam int ST_DCNT = 16;
    localparam int ST_ICNT = 24;

    typedef struct packed {
        logic [7:0] data;
        logic k;
        logic err;
    } xrm_sym_t;

    typedef struct packed {
        logic [LANES-1:0] ctl;
        logic [LANES*BYTE_W-1:0] data;
    } xrm_col_t;

    localparam xrm_col_t R_COL = '{ctl: '1, data: {LANES{R_BYTE}}};

    typedef enum logic {
        RM_WAIT = 1'b0,
        RM_RUN = 1'b1
    } xrm_rm_state_t;
endpackage : xrm_pkg

// ### hdl/xrm_rate_match.sv
// How it works
// [R1] fill marks leave room to absorb a total 200 ppm clock offset.
// [R2] the far transmitter sends idle /R/ on all four lanes as columns.
// [R3] rate matching starts only when sync and channel aligned are both set.
// [R4] whole all-/R/ columns are dropped at or above the high mark or repeated at or below the low mark.
// [R5] each deleted column pulses the delete flag of all lanes one cycle.
// [R6] each inserted column pulses the insert flag of all lanes one cycle.
// [R7] on full or empty nothing is patched; the flag stands three cycles.
// [R8] fabric answers a full or empty flag with a receive digital reset.
// [R9] the transmit reset clears transmit logic for at least two cycles.
// [R10] the receive reset clears receive logic for at least two cycles.
// [R11] the analog reset clears only the recovery unit, two cycles least.
// [R12] fabric keeps digital resets high until the clocks are stable.
// [R13] block power down forces every channel and pll into reset.
// [R14] each lane decoder runs on its own reset and its own state.
// [R15] each lane stream is decoded and packed into a 32 bit column.
// [R16] while receive reset stands the fifo is empty and its flags low.
// [R17] losing sync or alignment stops rate matching until both return.
module xrm_rate_match (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [xrm_pkg::LANES-1:0][xrm_pkg::CODE_W-1:0] rx_code,
    input wire logic rx_code_valid,
    input wire logic rd_tick,
    input wire logic sync_status,
    input wire logic channel_aligned,
    input wire logic [xrm_pkg::LANES-1:0] tx_digital_reset,
    input wire logic [xrm_pkg::LANES-1:0] rx_digital_reset,
    input wire logic [xrm_pkg::LANES-1:0] rx_analog_reset,
    input wire logic block_powerdown,
    input wire logic [xrm_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output xrm_pkg::xrm_col_t xgmii_out,
    output logic xgmii_valid,
    output logic [xrm_pkg::LANES-1:0] del_flag,
    output logic [xrm_pkg::LANES-1:0] ins_flag,
    output logic [xrm_pkg::LANES-1:0] full_flag,
    output logic [xrm_pkg::LANES-1:0] empty_flag,
    output logic [xrm_pkg::LANES-1:0] tx_pcs_reset,
    output logic [xrm_pkg::LANES-1:0] rx_pcs_reset,
    output logic [xrm_pkg::LANES-1:0] cdr_reset,
    output logic pll_powerdown,
    output logic irq
);
    localparam int L = xrm_pkg::LANES;
    localparam int NSRC = 3 * L + 1;
    localparam int RM = xrm_pkg::RST_MIN_CYC;

    // reset sources: tx, rx digital, rx analog per lane, then power down
    logic [NSRC-1:0] rst_src;
    wire logic [NSRC-1:0] rst_q;
    // [R13] power down everywhere
    assign rst_src = {block_powerdown, rx_analog_reset, rx_digital_reset,
        tx_digital_reset} | {NSRC{block_powerdown | ~nrst}};

    // async assert, release after RM clean edges; a short pulse still
    // gives the logic behind it a full minimum-width reset
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_rst
            logic [RM-1:0] sh;
            // [R9] stretch reset
            always_ff @(posedge clk or posedge rst_src[gi]) begin
                if (rst_src[gi]) begin
                    sh <= '1;
                end else begin
                    sh <= {sh[RM-2:0], 1'b0};
                end
            end
            assign rst_q[gi] = sh[RM-1];
        end
    endgenerate

    // split stretched resets onto their targets
    // [R10] receive pcs reset
    // [R11] analog reset to cdr only
    assign tx_pcs_reset = rst_q[L-1:0];
    assign rx_pcs_reset = rst_q[2*L-1:L];
    assign cdr_reset = rst_q[3*L-1:2*L];
    assign pll_powerdown = rst_q[3*L];

    // per lane decoders, each under its own receive reset
    xrm_pkg::xrm_sym_t sym [L];
    wire logic [L-1:0] sym_valid;
    wire logic [L-1:0] lane_nrst;
    wire xrm_pkg::xrm_col_t in_col;
    generate
        for (gi = 0; gi < L; gi++) begin : g_lane
            // [R12] clocks settle under reset
            assign lane_nrst[gi] = ~rx_pcs_reset[gi];
            // [R14] independent lane state
            xrm_lane_dec u_dec (
                .clk(clk),
                .nrst(lane_nrst[gi]),
                .code_valid(rx_code_valid),
                .code(rx_code[gi]),
                .sym(sym[gi]),
                .sym_valid(sym_valid[gi])
            );
            // [R15] pack lane into column
            assign in_col.data[gi*xrm_pkg::BYTE_W +: xrm_pkg::BYTE_W] =
                sym[gi].err ? xrm_pkg::ERR_BYTE : sym[gi].data;
            assign in_col.ctl[gi] = sym[gi].k | sym[gi].err;
        end
    endgenerate

    // fifo is held clear by any lane's receive reset
    // [R8] fabric reset clears fifo
    wire logic rm_nrst = ~(|rx_pcs_reset);

    // fifo storage and pointers
    xrm_pkg::xrm_col_t mem [xrm_pkg::FIFO_DEPTH];
    logic [xrm_pkg::PW-1:0] wr_ptr;
    logic [xrm_pkg::PW-1:0] rd_ptr;
    logic [1:0] full_hold;
    logic [1:0] empty_hold;
    logic last_r;
    logic primed;
    logic rm_en;
    xrm_pkg::xrm_rm_state_t state;
    xrm_pkg::xrm_rm_state_t next_state;

    // occupancy and gating
    wire logic [xrm_pkg::PW-1:0] fill = wr_ptr - rd_ptr;
    wire logic fifo_full = fill == xrm_pkg::FULL_LVL;
    wire logic fifo_empty = fill == '0;
    wire logic aligned = sync_status & channel_aligned;
    wire logic active = state == xrm_pkg::RM_RUN;
    wire logic in_valid = &sym_valid;
    // [R2] relies on idle columns
    wire logic is_r_in = in_col == xrm_pkg::R_COL;
    wire logic w_go = in_valid & active;
    // [R4] drop idle column high
    // [R1] high mark sets the slack
    wire logic delete = w_go & is_r_in & (fill >= xrm_pkg::HI_MARK);
    wire logic push = w_go & ~delete & ~fifo_full;
    // [R7] overflow is only flagged
    wire logic overflow = w_go & ~delete & fifo_full;
    // reads wait for half fill so a fresh run does not underrun at once
    wire logic r_go = rd_tick & active & primed;
    // [R4] repeat idle column low
    wire logic insert = r_go & last_r & (fill <= xrm_pkg::LO_MARK);
    wire logic pop = r_go & ~insert & ~fifo_empty;
    // [R7] underrun is only flagged
    wire logic underrun = r_go & ~insert & fifo_empty;
    wire logic align_lost = active & (next_state == xrm_pkg::RM_WAIT);
    wire logic [xrm_pkg::AW-1:0] wr_idx = wr_ptr[xrm_pkg::AW-1:0];
    wire logic [xrm_pkg::AW-1:0] rd_idx = rd_ptr[xrm_pkg::AW-1:0];

    // gate state: run only while aligned and enabled
    always_comb begin
        next_state = state;
        unique case (state)
            // [R3] start on sync and aligned
            xrm_pkg::RM_WAIT: begin
                if (aligned && rm_en) begin
                    next_state = xrm_pkg::RM_RUN;
                end
            end
            // [R17] stop on loss
            xrm_pkg::RM_RUN: begin
                if (!aligned || !rm_en) begin
                    next_state = xrm_pkg::RM_WAIT;
                end
            end
        endcase
    end

    // hold counters reload on every new event
    wire logic [1:0] next_full_hold = overflow ? xrm_pkg::HOLD_CYC
        : (full_hold != '0 ? full_hold - 2'h1 : full_hold);
    wire logic [1:0] next_empty_hold = underrun ? xrm_pkg::HOLD_CYC
        : (empty_hold != '0 ? empty_hold - 2'h1 : empty_hold);

    // storage has no reset; pointers guard every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_idx] <= in_col;
        end
    end

    // pointers, gate and priming; waiting flushes the fifo
    // [R16] flush under reset
    always_ff @(posedge clk or negedge rm_nrst) begin
        if (!rm_nrst) begin
            state <= xrm_pkg::RM_WAIT;
            wr_ptr <= '0;
            rd_ptr <= '0;
            primed <= 1'b0;
        end else if (!active) begin
            state <= next_state;
            wr_ptr <= '0;
            rd_ptr <= '0;
            primed <= 1'b0;
        end else begin
            state <= next_state;
            wr_ptr <= wr_ptr + xrm_pkg::PW'(push);
            rd_ptr <= rd_ptr + xrm_pkg::PW'(pop);
            primed <= primed | (fill >= xrm_pkg::MID_MARK);
        end
    end

    // output column and event flags
    // [R5] delete pulse all lanes
    // [R6] insert pulse all lanes
    always_ff @(posedge clk or negedge rm_nrst) begin
        if (!rm_nrst) begin
            xgmii_out <= '0;
            xgmii_valid <= 1'b0;
            last_r <= 1'b0;
            del_flag <= '0;
            ins_flag <= '0;
            full_hold <= '0;
            empty_hold <= '0;
        end else begin
            if (pop) begin
                xgmii_out <= mem[rd_idx];
                last_r <= mem[rd_idx] == xrm_pkg::R_COL;
            end else if (insert) begin
                xgmii_out <= xrm_pkg::R_COL;
            end
            xgmii_valid <= pop | insert;
            del_flag <= {L{delete}};
            ins_flag <= {L{insert}};
            full_hold <= next_full_hold;
            empty_hold <= next_empty_hold;
        end
    end

    // [R7] flags follow hold counters
    assign full_flag = {L{full_hold != '0}};
    assign empty_flag = {L{empty_hold != '0}};

    // register file: sticky events, enable, control, counters
    logic [xrm_pkg::EV_W-1:0] status;
    logic [xrm_pkg::EV_W-1:0] enable;
    logic [7:0] dcnt;
    logic [7:0] icnt;
    wire logic [xrm_pkg::EV_W-1:0] ev;
    assign ev[xrm_pkg::EV_DEL] = delete;
    assign ev[xrm_pkg::EV_INS] = insert;
    assign ev[xrm_pkg::EV_FULL] = overflow;
    assign ev[xrm_pkg::EV_EMPTY] = underrun;
    assign ev[xrm_pkg::EV_ALIGN] = align_lost;

    // address decode and read selection
    wire logic wr_clear = wr && addr == xrm_pkg::A_CLEAR;
    wire logic wr_enable = wr && addr == xrm_pkg::A_ENABLE;
    wire logic wr_control = wr && addr == xrm_pkg::A_CONTROL;
    wire logic [xrm_pkg::EV_W-1:0] clr =
        wr_clear ? wdata[xrm_pkg::EV_W-1:0] : '0;
    wire logic [31:0] st_word = 32'(fill)
        | (32'(active) << xrm_pkg::ST_ACT)
        | (32'(dcnt) << xrm_pkg::ST_DCNT)
        | (32'(icnt) << xrm_pkg::ST_ICNT);
    wire logic [31:0] rd_mux =
        addr == xrm_pkg::A_STATUS ? 32'(status)
        : addr == xrm_pkg::A_ENABLE ? 32'(enable)
        : addr == xrm_pkg::A_CONTROL ? 32'(rm_en)
        : addr == xrm_pkg::A_STATE ? st_word : '0;

    // set wins over a clear landing in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
            enable <= '0;
            rm_en <= xrm_pkg::CTRL_RM_EN_RST;
            dcnt <= '0;
            icnt <= '0;
            rdata <= '0;
        end else begin
            status <= (status & ~clr) | ev;
            if (wr_enable) begin
                enable <= wdata[xrm_pkg::EV_W-1:0];
            end
            if (wr_control) begin
                rm_en <= wdata[xrm_pkg::CTRL_RM_EN];
            end
            dcnt <= dcnt + 8'(delete);
            icnt <= icnt + 8'(insert);
            rdata <= rd ? rd_mux : '0;
        end
    end

    // level interrupt from any enabled sticky bit
    assign irq = |(status & enable);

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_full_hold;
        full_flag[0] [*3];
    endsequence

    sequence s_empty_hold;
        empty_flag[0] [*3];
    endsequence

    sequence s_tx_hold;
        tx_pcs_reset[0] [*3];
    endsequence

    AST_DEL_PULSE: assert property ( // [R5]
        delete |=> del_flag == '1 ##1 del_flag == {L{$past(delete)}})
        else $error("delete flag does not follow deleted column");
    AST_INS_PULSE: assert property ( // [R6]
        insert |=> ins_flag == '1 && xgmii_valid && xgmii_out == xrm_pkg::R_COL)
        else $error("insert flag or idle column missing");
    AST_FULL_HOLD: assert property ( // [R7]
        overflow |=> s_full_hold)
        else $error("full flag shorter than three cycles");
    AST_EMPTY_HOLD: assert property ( // [R7]
        underrun |=> !xgmii_valid ##0 s_empty_hold)
        else $error("empty flag short or column invented");
    AST_NO_RM_UNALIGNED: assert property ( // [R3]
        !active |=> del_flag == '0 && ins_flag == '0 && !xgmii_valid)
        else $error("rate matching while not aligned");
    AST_STOP_ON_LOSS: assert property ( // [R17]
        active && !aligned |=> !active ##1 fill == '0)
        else $error("rate matching did not stop on loss");
    AST_RX_RESET_CLEAR: assert property ( // [R16]
        rx_digital_reset[0] |-> fill == '0 && full_flag == '0
        && empty_flag == '0 && del_flag == '0)
        else $error("fifo not cleared under receive reset");
    AST_TX_RESET_MIN: assert property ( // [R9]
        $rose(tx_digital_reset[0]) |-> s_tx_hold)
        else $error("transmit reset shorter than minimum");
    AST_CDR_RESET_MIN: assert property ( // [R11]
        $fell(rx_analog_reset[0]) && !block_powerdown |->
        cdr_reset[0] ##1 cdr_reset[0] ##1 !cdr_reset[0] || rst_src[2*L])
        else $error("analog reset release out of step");
    AST_POWERDOWN: assert property ( // [R13]
        block_powerdown |-> pll_powerdown && tx_pcs_reset == '1
        && rx_pcs_reset == '1 && cdr_reset == '1)
        else $error("power down did not reach every channel");
    AST_DELETE_HIGH: assert property ( // [R4]
        delete |-> fill >= xrm_pkg::HI_MARK && is_r_in ##1 $stable(wr_ptr))
        else $error("column deleted below high mark");
endmodule : xrm_rate_match

// ### tb/test_xrm_rate_match.sv
module test_xrm_rate_match;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, rd_tick, sync_status, channel_aligned, block_powerdown;
    logic [3:0] tx_digital_reset, rx_digital_reset, rx_analog_reset;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic wr, rd, xgmii_valid, pll_powerdown, irq, rx_code_valid;
    logic send, idle, sent, rd_q, track;
    logic [3:0] del_flag, ins_flag, full_flag, empty_flag;
    logic [3:0] tx_pcs_reset, rx_pcs_reset, cdr_reset;
    logic [3:0][9:0] rx_code;
    xrm_pkg::xrm_col_t xgmii_out, col;
    xrm_pkg::xrm_col_t dq[$];
    logic [63:0] rq[$];
    logic [63:0] rd_e;
    int n_mismatch, n_compared, n_del, n_ins, n_out, f_run, e_run, cycles;
    wire [12:0] outs = {pll_powerdown, cdr_reset, rx_pcs_reset, tx_pcs_reset};

    xrm_rate_match dut (.*);
    xrm_link_model link (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [39:0] got, input logic [39:0] exp,
                         input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask : check

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // output watcher: each result takes the oldest note off its queue
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            end_of_test();
        end
        if (rd_q && rq.size() > 0) begin
            rd_e = rq.pop_front();
            check(rdata & rd_e[63:32], rd_e[31:0], "read");
        end
        rd_q <= rd;
        if (sent && track)
            dq.push_back(col);
        if (xgmii_valid)
            n_out++;
        if (xgmii_valid && track && ins_flag !== 0)
            check({ins_flag, xgmii_out}, {4'hF, xrm_pkg::R_COL}, "insert");
        else if (xgmii_valid && track && xgmii_out !== xrm_pkg::R_COL)
            check(xgmii_out, dq.pop_front(), "column");
        if (del_flag !== 0)
            n_del++;
        if (del_flag !== 0)
            check(del_flag, 4'hF, "delete lanes");
        if (ins_flag !== 0)
            n_ins++;
        // a short flag could be missed by slow fabric logic
        if (full_flag === 0 && f_run != 0)
            check(f_run >= 3, 1, "full hold");
        if (empty_flag === 0 && e_run != 0)
            check(e_run >= 3, 1, "empty hold");
        f_run = full_flag !== 0 ? f_run + 1 : 0;
        e_run = empty_flag !== 0 ? e_run + 1 : 0;
    end

    // traffic: ws/rs skip every nth write/read, 1 means none at all
    task automatic run(input int n, input int ws, input int rs,
                       input int mode);
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            send <= ws == 0 || i % ws != 0;
            rd_tick <= rs == 0 || i % rs != 0;
            idle <= mode == 0 ? 1'($urandom_range(1)) : mode == 1;
        end
        @(posedge clk);
        send <= 1'b0;
        rd_tick <= 1'b0;
        // let the last columns and flags drain before counts are read
        repeat (4) @(posedge clk);
    endtask : run

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m);
        rq.push_back({m, e});
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
    endtask : reg_rd

    task automatic rel_check(input logic [12:0] e);
        @(posedge clk);
        #1 check(outs, e, "stretch");
        @(posedge clk);
        #1 check(outs, 0, "release");
    endtask : rel_check

    // pulse one reset input on lane 0, or power down the block
    task automatic rst_pulse(input int s);
        @(posedge clk);
        tx_digital_reset <= s == 0 ? 4'h1 : 4'h0;
        rx_digital_reset <= s == 1 ? 4'h1 : 4'h0;
        rx_analog_reset <= s == 2 ? 4'h1 : 4'h0;
        block_powerdown <= s == 3;
        #1 check(outs, s == 3 ? 13'h1FFF : 13'h1 << 4 * s, "set");
        if (s == 1 || s == 3)
            check({full_flag, empty_flag, ins_flag, del_flag}, 0, "fl");
        repeat (2) @(posedge clk); // shortest legal pulse
        {tx_digital_reset, rx_digital_reset, rx_analog_reset} <= '0;
        block_powerdown <= 1'b0;
        rel_check(s == 3 ? 13'h1FFF : 13'h1 << 4 * s);
        done("reset input");
    endtask : rst_pulse

    initial begin
        {nrst, rd_tick, sync_status, channel_aligned, block_powerdown} = '0;
        {tx_digital_reset, rx_digital_reset, rx_analog_reset} = '0;
        {addr, wdata, wr, rd, send, idle, rd_q, track} = '0;
        {n_mismatch, n_compared, n_del, n_ins, n_out} = '0;
        {f_run, e_run, cycles} = '0;
        void'($urandom(81));
        repeat (5) @(posedge clk);
        #1 check(outs, 13'h1FFF, "in reset");
        @(posedge clk);
        nrst <= 1'b1;
        rel_check(13'h1FFF);
        reg_wr(xrm_pkg::A_STATUS, 32'hFFFFFFFF);
        reg_rd(xrm_pkg::A_STATUS, 0, '1);
        reg_rd(xrm_pkg::A_CONTROL, 1, '1);
        reg_rd(xrm_pkg::A_ENABLE, 0, '1);
        reg_rd(xrm_pkg::A_CLEAR, 0, '1);
        reg_rd(8'hFC, 0, '1);
        // held off until sync and alignment
        sync_status <= 1'b1;
        run(40, 0, 0, 0);
        check(n_out, 0, "gated");
        reg_rd(xrm_pkg::A_STATE, 0, 32'h100);
        channel_aligned <= 1'b1;
        track <= 1'b1;
        done("gate");
        // fast writer, then slow writer, each followed by an equal rates drain
        run(400, 0, 8, 0);
        run(60, 0, 0, 1);
        check(dq.size(), 0, "drained");
        check(n_del > 0, 1, "deleted");
        reg_rd(xrm_pkg::A_STATE, {n_del[7:0], 16'h0}, 32'hFF0000);
        run(400, 8, 0, 0);
        run(60, 0, 0, 1);
        check(dq.size(), 0, "drained");
        check(n_ins > 0, 1, "inserted");
        reg_rd(xrm_pkg::A_STATE, {n_ins[7:0], 24'h0}, 32'hFF000000);
        reg_rd(xrm_pkg::A_STATUS, 32'h3, 32'h3);
        reg_wr(xrm_pkg::A_ENABLE, 32'h3);
        #1 check(irq, 1, "irq on");
        reg_wr(xrm_pkg::A_CLEAR, 32'h1F);
        #1 check(irq, 0, "irq cleared");
        done("slip");
        // data only, reads outrun writes: nothing added or lost
        run(80, 4, 0, 2);
        run(60, 0, 0, 1);
        check(dq.size(), 0, "no patching");
        reg_rd(xrm_pkg::A_STATUS, 32'h8, 32'h8);
        channel_aligned <= 1'b0;
        reg_rd(xrm_pkg::A_STATE, 0, 32'h100);
        reg_rd(xrm_pkg::A_STATUS, 32'h10, 32'h10);
        channel_aligned <= 1'b1;
        done("underrun");
        // overrun, then the fabric's receive reset
        track <= 1'b0;
        run(60, 0, 1, 2);
        reg_rd(xrm_pkg::A_STATUS, 32'h4, 32'h4);
        reg_wr(xrm_pkg::A_ENABLE, 32'h4);
        #1 check(irq, 1, "full irq");
        rst_pulse(1);
        reg_rd(xrm_pkg::A_STATE, 0, 32'h1F);
        reg_wr(xrm_pkg::A_CLEAR, 32'h1F);
        #1 check(irq, 0, "irq cleared");
        rst_pulse(0);
        rst_pulse(2);
        rst_pulse(3);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule : test_xrm_rate_match

// ### tb/xrm_link_model.sv
// upstream link transmitter: one column of four code groups per send
module xrm_link_model (
    input wire logic clk,
    input wire logic send,
    input wire logic idle,
    output logic [3:0][9:0] rx_code,
    output logic rx_code_valid,
    output xrm_pkg::xrm_col_t col,
    output logic sent
);
    timeunit 1ns;
    timeprecision 1ns;
    int x;
    int y;
    initial begin
        rx_code = '0;
        rx_code_valid = 1'b0;
        sent = 1'b0;
    end
    // data bytes avoid the alternate x.7 codes, so one table lookup is enough
    // idle on all lanes
    always @(posedge clk) begin
        rx_code_valid <= send;
        sent <= send && !idle;
        col.ctl <= '0;
        for (int i = 0; i < 4; i++) begin
            x = $urandom_range(31);
            y = $urandom_range(6);
            if (!send)
                rx_code[i] <= ~rx_code[i]; // unused cycles never look valid
            else if (idle)
                rx_code[i] <= xrm_pkg::K28_0_NEG;
            else
                rx_code[i] <= {xrm_pkg::TBL6[x], xrm_pkg::TBL4[y]};
            col.data[8*i+:8] <= {y[2:0], x[4:0]};
        end
    end
endmodule : xrm_link_model
